// ==== rtl/fap_pkg.sv ====
// Purpose: Shared constants for the address-phase parity block
// Assumes: Active-low bus lines seen as plain logic levels at the pins
// Notes: Widths follow the bus address path of lines 35 down to 3
package fap_pkg;
	localparam int ADDR_HI = 35;
	localparam int ADDR_LO = 3;
	localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
	localparam int PHYS_W = 36;
	localparam int UPPER_HI = 35;
	localparam int UPPER_LO = 24;
	localparam int LOWER_HI = 23;
	localparam int LOWER_LO = 3;
	localparam int MASK_BIT = 20;
	localparam int REQ_W = 5;
	localparam int SYNC_STAGES = 3;
	localparam logic [ADDR_W-1:0] ADDR_IDLE = 33'h1_FFFF_FFFF;
	localparam logic [REQ_W-1:0] REQ_IDLE = 5'h1F;
	localparam logic [1:0] PAR_IDLE = 2'h3;
endpackage

// ==== rtl/fap_sync.sv ====
// Purpose: Three-stage synchroniser for an asynchronous level input
// Assumes: Reset value given by parameter
// Notes: Output changes once the second and third stages agree
module fap_sync #(
	parameter logic RST_VAL = 1'b1
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// Level in and out
	input wire logic i_async,
	output logic o_sync
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic out;
	} fap_sync_st_t;

	fap_sync_st_t st_q;
	fap_sync_st_t st_d;

	always_comb
	begin
		st_d = st_q;
		st_d.s1 = i_async;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (st_q.s2 == st_q.s3)
		begin
			st_d.out = st_q.s3;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			st_q <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign o_sync = st_q.out;
endmodule

// ==== rtl/fap_addr_phase.sv ====
// Purpose: Address-phase driver and checker with parity and bit-20 mask
// Assumes: Bus pins are split into input, output and output enable
// Notes: Active-low pins carry _n; enables are high while driving
//
// Summary of operation
// - The address path is lines 35 to 3 of a 36-bit byte address; bits 2 to 0 are not carried.
// - With the strobe asserted the lines hold the address, otherwise they are released high.
// - Upper parity covers lines 35 to 24 and lower parity covers lines 23 to 3.
// - A parity pin is high when an even number of its covered active-low lines are low.
// - The initiator drives parity in the same clock as strobe, address, command and request parity.
// - On reset release the address lines are sampled as power-on configuration.
// - With the bit-20 mask asserted, address bit 20 is forced off for lookup and bus requests.
// - A sampled strobe starts the transaction and its address parity check.
// - If enabled at configuration, a valid parity error assertion aborts the current transaction.
// - All outputs are driven and inputs latched on the rising bus clock edge.
module fap_addr_phase #(
	parameter int CFG_ADDR_PARITY_ERROR_N_BIT = 0
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// Core request side
	input wire logic i_req_valid,
	input wire logic [fap_pkg::PHYS_W-1:0] i_req_addr,
	input wire logic [fap_pkg::REQ_W-1:0] i_req_cmd,
	input wire logic i_lookup_valid,
	input wire logic [fap_pkg::PHYS_W-1:0] i_lookup_addr,
	output logic [fap_pkg::PHYS_W-1:0] o_lookup_addr,
	output logic o_req_taken,
	// Bit-20 mask, asynchronous
	input wire logic i_addr_bit20_mask_n,
	// Address strobe pin
	input wire logic i_addr_strobe_n,
	output logic o_addr_strobe_n,
	output logic o_addr_strobe_oe,
	// Address pins
	input wire logic [fap_pkg::ADDR_W-1:0] i_addr_n,
	output logic [fap_pkg::ADDR_W-1:0] o_addr_n,
	output logic o_addr_oe,
	// Request command and request parity pins
	output logic [fap_pkg::REQ_W-1:0] o_req_n,
	output logic o_request_parity_n,
	output logic o_req_oe,
	// Address parity pins, bit 1 upper and bit 0 lower
	input wire logic [1:0] i_addr_parity_n,
	output logic [1:0] o_addr_parity_n,
	output logic o_addr_parity_oe,
	// Address parity error pin
	input wire logic i_addr_parity_error_n,
	output logic o_addr_parity_error_n,
	output logic o_addr_parity_error_oe,
	// Observed transaction and status
	output logic o_txn_start,
	output logic [fap_pkg::PHYS_W-1:0] o_txn_addr,
	output logic o_txn_abort,
	output logic o_parity_fail,
	output logic [fap_pkg::ADDR_W-1:0] o_poc_cfg,
	output logic o_poc_valid
);
	// Configuration bit must be one of the sampled address lines
	if (CFG_ADDR_PARITY_ERROR_N_BIT < 0 || CFG_ADDR_PARITY_ERROR_N_BIT >= fap_pkg::ADDR_W)
	begin : g_bad_cfg
		$error("CFG_ADDR_PARITY_ERROR_N_BIT out of range");
	end

	typedef struct packed {
		logic ads_o;
		logic ads_oe;
		logic [fap_pkg::ADDR_W-1:0] a_o;
		logic a_oe;
		logic [fap_pkg::REQ_W-1:0] req_o;
		logic rp_o;
		logic req_oe;
		logic [1:0] ap_o;
		logic ap_oe;
		logic addr_parity_error_n_o;
		logic addr_parity_error_n_oe;
		logic taken;
		logic [fap_pkg::PHYS_W-1:0] lk;
		logic ads_s;
		logic [fap_pkg::ADDR_W-1:0] a_s;
		logic [1:0] ap_s;
		logic chk;
		logic addr_parity_error_n_s;
		logic start;
		logic [fap_pkg::PHYS_W-1:0] txa;
		logic abort;
		logic pfail;
		logic rst_seen;
		logic [fap_pkg::ADDR_W-1:0] poc;
		logic poc_v;
		logic addr_parity_error_n_en;
	} fap_st_t;

	fap_st_t st_q;
	fap_st_t st_d;
	logic mask_n_sync;

	fap_sync #(
		.RST_VAL(1'b1)
	) u_mask_sync (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_async(i_addr_bit20_mask_n),
		.o_sync(mask_n_sync)
	);

	// Ones in v mark low lines; an even count of them gives high parity
	function automatic logic [1:0] addr_par_n(input logic [fap_pkg::ADDR_W-1:0] an);
		logic [fap_pkg::ADDR_W-1:0] v;
		v = ~an;
		addr_par_n[1] = ~^v[fap_pkg::UPPER_HI-fap_pkg::ADDR_LO:fap_pkg::UPPER_LO-fap_pkg::ADDR_LO];
		addr_par_n[0] = ~^v[fap_pkg::LOWER_HI-fap_pkg::ADDR_LO:fap_pkg::LOWER_LO-fap_pkg::ADDR_LO];
	endfunction

	function automatic logic [fap_pkg::PHYS_W-1:0] mask20(input logic [fap_pkg::PHYS_W-1:0] a,
		input logic m);
		mask20 = a;
		if (m)
		begin
			mask20[fap_pkg::MASK_BIT] = 1'b0;
		end
	endfunction

	always_comb
	begin
		logic [fap_pkg::PHYS_W-1:0] ra;
		logic [fap_pkg::ADDR_W-1:0] an;
		logic mask_on;
		ra = '0;
		an = '0;
		mask_on = ~mask_n_sync;
		st_d = st_q;
		// Input latches on the rising edge
		st_d.ads_s = ~i_addr_strobe_n;
		st_d.a_s = i_addr_n;
		st_d.ap_s = i_addr_parity_n;
		st_d.addr_parity_error_n_s = ~i_addr_parity_error_n;
		// Masked cache lookup address
		st_d.lk = mask20(i_lookup_valid ? i_lookup_addr : st_q.lk, mask_on);
		// Initiator: one clock address phase, everything in the same clock
		st_d.taken = 1'b0;
		st_d.ads_o = 1'b1;
		st_d.ads_oe = 1'b0;
		st_d.a_oe = 1'b0;
		st_d.a_o = fap_pkg::ADDR_IDLE;
		st_d.req_o = fap_pkg::REQ_IDLE;
		st_d.rp_o = 1'b1;
		st_d.req_oe = 1'b0;
		st_d.ap_o = fap_pkg::PAR_IDLE;
		st_d.ap_oe = 1'b0;
		if (i_req_valid && !st_q.ads_oe && st_q.rst_seen)
		begin
			ra = mask20(i_req_addr, mask_on);
			an = ~ra[fap_pkg::ADDR_HI:fap_pkg::ADDR_LO];
			st_d.taken = 1'b1;
			st_d.ads_o = 1'b0;
			st_d.ads_oe = 1'b1;
			st_d.a_o = an;
			st_d.a_oe = 1'b1;
			st_d.req_o = ~i_req_cmd;
			st_d.rp_o = ~^i_req_cmd;
			st_d.req_oe = 1'b1;
			st_d.ap_o = addr_par_n(an);
			st_d.ap_oe = 1'b1;
		end
		// Observer: strobe sampled starts checks next clock
		st_d.start = st_q.ads_s;
		st_d.chk = st_q.ads_s;
		st_d.txa = st_q.ads_s ? {~st_q.a_s, 3'h0} : st_q.txa;
		st_d.pfail = 1'b0;
		st_d.addr_parity_error_n_o = 1'b1;
		st_d.addr_parity_error_n_oe = 1'b0;
		if (st_q.ads_s && (addr_par_n(st_q.a_s) != st_q.ap_s))
		begin
			st_d.pfail = 1'b1;
			st_d.addr_parity_error_n_o = 1'b0;
			st_d.addr_parity_error_n_oe = 1'b1;
		end
		// Abort only when observation enabled at configuration
		st_d.abort = st_q.addr_parity_error_n_s && st_q.addr_parity_error_n_en && st_q.poc_v;
		// Capture configuration on first clock after reset release
		st_d.rst_seen = 1'b1;
		if (!st_q.rst_seen)
		begin
			st_d.poc = ~i_addr_n;
			st_d.poc_v = 1'b1;
			st_d.addr_parity_error_n_en = ~i_addr_n[CFG_ADDR_PARITY_ERROR_N_BIT];
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			st_q <= '0;
			st_q.ads_o <= 1'b1;
			st_q.a_o <= fap_pkg::ADDR_IDLE;
			st_q.req_o <= fap_pkg::REQ_IDLE;
			st_q.rp_o <= 1'b1;
			st_q.ap_o <= fap_pkg::PAR_IDLE;
			st_q.addr_parity_error_n_o <= 1'b1;
			st_q.a_s <= fap_pkg::ADDR_IDLE;
			st_q.ap_s <= fap_pkg::PAR_IDLE;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign o_lookup_addr = st_q.lk;
	assign o_req_taken = st_q.taken;
	assign o_addr_strobe_n = st_q.ads_o;
	assign o_addr_strobe_oe = st_q.ads_oe;
	assign o_addr_n = st_q.a_o;
	assign o_addr_oe = st_q.a_oe;
	assign o_req_n = st_q.req_o;
	assign o_request_parity_n = st_q.rp_o;
	assign o_req_oe = st_q.req_oe;
	assign o_addr_parity_n = st_q.ap_o;
	assign o_addr_parity_oe = st_q.ap_oe;
	assign o_addr_parity_error_n = st_q.addr_parity_error_n_o;
	assign o_addr_parity_error_oe = st_q.addr_parity_error_n_oe;
	assign o_txn_start = st_q.start;
	assign o_txn_addr = st_q.txa;
	assign o_txn_abort = st_q.abort;
	assign o_parity_fail = st_q.pfail;
	assign o_poc_cfg = st_q.poc;
	assign o_poc_valid = st_q.poc_v;
endmodule

// ==== verif/fap_assertions.sv ====
// Purpose: Port-level checks of the address-phase parity block
// Assumes: Inputs are the resolved bus lines
// Notes: Bound from the bench top file
module fap_assertions #(
	parameter int CFG_ADDR_PARITY_ERROR_N_BIT = 0
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// Inputs seen by the block
	input wire logic i_lookup_valid,
	input wire logic i_addr_bit20_mask_n,
	input wire logic i_addr_strobe_n,
	input wire logic [32:0] i_addr_n,
	input wire logic [1:0] i_addr_parity_n,
	input wire logic i_addr_parity_error_n,
	// Outputs of the block
	input wire logic [35:0] o_lookup_addr,
	input wire logic o_req_taken,
	input wire logic o_addr_strobe_n,
	input wire logic o_addr_strobe_oe,
	input wire logic [32:0] o_addr_n,
	input wire logic o_addr_oe,
	input wire logic o_req_oe,
	input wire logic [1:0] o_addr_parity_n,
	input wire logic o_addr_parity_oe,
	input wire logic o_addr_parity_error_n,
	input wire logic o_addr_parity_error_oe,
	input wire logic o_txn_start,
	input wire logic o_txn_abort,
	input wire logic o_parity_fail,
	input wire logic [32:0] o_poc_cfg,
	input wire logic o_poc_valid
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	sequence s_obs;
		!i_addr_strobe_n;
	endsequence
	sequence s_bad;
		s_obs ##0 i_addr_parity_n != {~^(~i_addr_n[32:21]), ~^(~i_addr_n[20:0])};
	endsequence
	sequence s_good;
		s_obs ##0 i_addr_parity_n == {~^(~i_addr_n[32:21]), ~^(~i_addr_n[20:0])};
	endsequence
	a_par_upper: assert property (
		o_addr_parity_oe |-> o_addr_parity_n[1] == ~^(~o_addr_n[32:21]))
		else $error("upper parity wrong");
	a_par_lower: assert property (
		o_addr_parity_oe |-> o_addr_parity_n[0] == ~^(~o_addr_n[20:0]))
		else $error("lower parity wrong");
	a_same_clock: assert property (
		o_addr_strobe_oe |-> !o_addr_strobe_n && o_addr_oe && o_req_oe && o_addr_parity_oe
		&& o_req_taken)
		else $error("request lines not together");
	a_one_cycle: assert property (o_req_taken |=> !o_req_taken && !o_addr_strobe_oe)
		else $error("request drive too long");
	a_strobe_start: assert property (s_obs |-> ##2 o_txn_start)
		else $error("no transaction start");
	a_err_drive: assert property (
		s_bad |-> ##2 o_parity_fail && o_addr_parity_error_oe && !o_addr_parity_error_n)
		else $error("parity error not driven");
	a_no_false_err: assert property (s_good |-> ##2 !o_parity_fail)
		else $error("false parity error");
	a_err_abort: assert property (
		!i_addr_parity_error_n && o_poc_cfg[CFG_ADDR_PARITY_ERROR_N_BIT] |-> ##2 o_txn_abort)
		else $error("no abort");
	a_no_abort: assert property (
		!i_addr_parity_error_n && !o_poc_cfg[CFG_ADDR_PARITY_ERROR_N_BIT] |-> ##2 !o_txn_abort)
		else $error("abort while observation disabled");
	a_bit20_mask: assert property (
		!i_addr_bit20_mask_n [*5] ##0 i_lookup_valid |=> !o_lookup_addr[20])
		else $error("bit 20 not masked");
	a_poc_capture: assert property (
		$rose(i_rstn) |=> o_poc_valid && o_poc_cfg == ~$past(i_addr_n))
		else $error("bad configuration capture");
endmodule

// ==== verif/fap_agent.sv ====
// Purpose: Far-side agent that issues strobed addresses
// Assumes: Released lines float to the pull-up level
// Notes: Parity may be spoiled on request
module fap_agent (
	// Clock
	input wire logic i_sys_clk,
	// Bus drive, all high when released
	output logic o_strobe_n,
	output logic [32:0] o_addr_n,
	output logic [1:0] o_par_n
);
	initial
	begin
		o_strobe_n = 1'b1;
		o_addr_n = fap_pkg::ADDR_IDLE;
		o_par_n = fap_pkg::PAR_IDLE;
	end
	task automatic hold(input logic [32:0] n);
		o_addr_n = n;
	endtask
	task automatic put(input logic [35:0] a, input logic bad);
		@(posedge i_sys_clk);
		#1;
		o_strobe_n = 1'b0;
		o_addr_n = ~a[35:3];
		o_par_n = {~^a[35:24], ~^a[23:3]} ^ {bad, bad};
		@(posedge i_sys_clk);
		#1;
		o_strobe_n = 1'b1;
		o_addr_n = fap_pkg::ADDR_IDLE;
		o_par_n = fap_pkg::PAR_IDLE;
	endtask
endmodule

// ==== verif/fap_addr_phase_tb.sv ====
// Purpose: Self-checking bench for the address-phase parity block
// Assumes: Bus lines resolve as a wired AND with pull-ups
// Notes: The block also sees its own driven cycles
module fap_addr_phase_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_req_valid = 1'b0;
	logic [35:0] i_req_addr = 36'h0;
	logic [4:0] i_req_cmd = 5'h15;
	logic i_lookup_valid = 1'b0;
	logic [35:0] i_lookup_addr = 36'h0;
	logic i_addr_bit20_mask_n = 1'b1;
	int error_cnt = 0;
	int total_checks = 0;
	wire [35:0] o_lookup_addr, o_txn_addr;
	wire o_req_taken, o_addr_strobe_n, o_addr_strobe_oe, o_addr_oe, o_req_oe, o_addr_parity_oe;
	wire o_addr_parity_error_n, o_addr_parity_error_oe, o_txn_start, o_txn_abort, o_parity_fail;
	wire o_poc_valid, ag_st, o_request_parity_n;
	wire [32:0] o_addr_n, o_poc_cfg, ag_a;
	wire [4:0] o_req_n;
	wire [1:0] o_addr_parity_n, ag_p;
	wire i_addr_strobe_n = (o_addr_strobe_oe ? o_addr_strobe_n : 1'b1) & ag_st;
	wire [32:0] i_addr_n = (o_addr_oe ? o_addr_n : fap_pkg::ADDR_IDLE) & ag_a;
	wire [1:0] i_addr_parity_n = (o_addr_parity_oe ? o_addr_parity_n : 2'h3) & ag_p;
	wire i_addr_parity_error_n = o_addr_parity_error_oe ? o_addr_parity_error_n : 1'b1;
	wire [3:0] flags = {o_txn_start, o_txn_abort, o_parity_fail, o_req_taken};
	always #4 i_sys_clk = ~i_sys_clk;
	fap_addr_phase u_fap_addr_phase (.i_sys_clk, .i_rstn, .i_req_valid, .i_req_addr, .i_req_cmd,
		.i_lookup_valid, .i_lookup_addr, .o_lookup_addr, .o_req_taken, .i_addr_bit20_mask_n,
		.i_addr_strobe_n, .o_addr_strobe_n, .o_addr_strobe_oe, .i_addr_n, .o_addr_n, .o_addr_oe,
		.o_req_n, .o_request_parity_n, .o_req_oe, .i_addr_parity_n, .o_addr_parity_n,
		.o_addr_parity_oe, .i_addr_parity_error_n, .o_addr_parity_error_n, .o_addr_parity_error_oe,
		.o_txn_start, .o_txn_addr, .o_txn_abort, .o_parity_fail, .o_poc_cfg, .o_poc_valid);
	fap_agent u_fap_agent (.i_sys_clk, .o_strobe_n(ag_st), .o_addr_n(ag_a), .o_par_n(ag_p));
	task automatic tick;
		@(posedge i_sys_clk);
		#1;
	endtask
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_flag(input int b);
		int n;
		for (n = 0; n < 8 && flags[b] !== 1'b1; n++)
			tick();
		if (n == 8)
		begin
			error_cnt++;
			$display("[FAIL] %0t flag %0d timeout got %h exp %h", $time, b, flags[b], 1'b1);
			stop_test();
		end
	endtask
	// Reset for 4 clocks with a configuration held on the lines, also usable mid-run
	task automatic t_config(input logic [32:0] cfg_n, input logic [32:0] exp);
		i_rstn = 1'b0;
		tick();
		u_fap_agent.hold(cfg_n);
		repeat (3) tick();
		chk(o_poc_valid, 1'b0);
		i_rstn = 1'b1;
		tick();
		u_fap_agent.hold(fap_pkg::ADDR_IDLE);
		chk(o_poc_cfg, exp);
		chk(o_poc_valid, 1'b1);
	endtask
	task automatic t_req(input logic [35:0] a, input logic [35:0] exp);
		logic [32:0] n;
		n = ~exp[35:3];
		i_req_addr = a;
		i_req_valid = 1'b1;
		tick();
		i_req_valid = 1'b0;
		chk(o_req_taken, 1'b1);
		chk(o_addr_n, n);
		chk(o_addr_parity_n, {~^exp[35:24], ~^exp[23:3]});
		chk(o_req_n, 5'h0A);
		// Command 15h puts three lines low, an odd count, so request parity is low
		chk(o_request_parity_n, 1'b0);
		wait_flag(3);
		chk(o_txn_addr, exp);
		chk(o_parity_fail, 1'b0);
	endtask
	task automatic t_mask;
		i_addr_bit20_mask_n = 1'b0;
		repeat (5) tick();
		i_lookup_valid = 1'b1;
		i_lookup_addr = 36'hF_FFFF_FFFF;
		tick();
		i_lookup_valid = 1'b0;
		chk(o_lookup_addr, 36'hF_FFEF_FFFF);
		t_req(36'h0_0010_0008, 36'h0_0000_0008);
		i_addr_bit20_mask_n = 1'b1;
	endtask
	// Abort shows two clocks after the error drive, which stands with the start pulse
	task automatic t_obs(input logic [35:0] a, input logic bad, input logic ab);
		u_fap_agent.put(a, bad);
		wait_flag(3);
		chk(o_txn_addr, a);
		chk(o_parity_fail, bad);
		chk(o_addr_parity_error_oe, bad);
		repeat (2) tick();
		chk(o_txn_abort, ab);
	endtask
	initial
	begin
		t_config(33'h1_2345_6788, 33'h0_DCBA_9877);
		t_req(36'h9_8765_432F, 36'h9_8765_4328);
		t_mask();
		t_obs(36'hA_5A5A_5A58, 1'b0, 1'b0);
		t_obs(36'h1_0000_0008, 1'b1, 1'b1);
		t_config(33'h0_0000_0001, 33'h1_FFFF_FFFE);
		t_obs(36'h1_0000_0008, 1'b1, 1'b0);
		stop_test();
	end
endmodule
bind fap_addr_phase fap_assertions #(.CFG_ADDR_PARITY_ERROR_N_BIT(CFG_ADDR_PARITY_ERROR_N_BIT)) u_fap_assertions (.i_sys_clk,
	.i_rstn, .i_lookup_valid, .i_addr_bit20_mask_n, .i_addr_strobe_n, .i_addr_n, .i_addr_parity_n,
	.i_addr_parity_error_n, .o_lookup_addr, .o_req_taken, .o_addr_strobe_n, .o_addr_strobe_oe,
	.o_addr_n, .o_addr_oe, .o_req_oe, .o_addr_parity_n, .o_addr_parity_oe, .o_addr_parity_error_n,
	.o_addr_parity_error_oe, .o_txn_start, .o_txn_abort, .o_parity_fail, .o_poc_cfg, .o_poc_valid);
